// >>> common/pt8_pkg.sv
package pt8_pkg;
    localparam int ADDR_W = 12;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_FLAG = 10'h00c;
    localparam logic [9:0] IDX_COUNT = 10'h011;
    localparam logic [9:0] IDX_CTRL = 10'h012;
    localparam logic [9:0] IDX_ENABLE = 10'h08c;
    localparam logic [9:0] IDX_PERIOD = 10'h092;
    localparam logic [1:0] WORD_LANE = 2'h0;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'hff;
    localparam logic [7:0] ENABLE_RST = 8'h00;
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam int RUN_BIT = 2;
    localparam int PS_MSB = 1;
    localparam int POST_LSB = 3;
    localparam int POST_MSB = 6;
    localparam int TMR_FLAG_BIT = 1;
    localparam int TMR_EN_BIT = 1;
    // instruction clock is the oscillator divided by four
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
    localparam logic [3:0] PRESC_LAST_1 = 4'h0;
    localparam logic [3:0] PRESC_LAST_4 = 4'h3;
    localparam logic [3:0] PRESC_LAST_16 = 4'hf;
    localparam logic [1:0] PRESC_SEL_1 = 2'h0;
    localparam logic [1:0] PRESC_SEL_4 = 2'h1;
    typedef enum logic [1:0] {
        PT8_IDLE = 2'b01,
        PT8_RESP = 2'b10
    } pt8_bus_e;
endpackage

// >>> common/pt8_scale_if.sv
`timescale 1ns/1ps
interface pt8_scale_if;
    logic clear;
    logic tick;
    logic [3:0] sel;
    logic pulse;
    modport master (output clear, output tick, output sel, input pulse);
    modport scaler (input clear, input tick, input sel, output pulse);
endinterface

// >>> logic/pt8_postscaler.sv
`timescale 1ns/1ps
module pt8_postscaler
    import pt8_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // tick = period match, sel = ratio minus one, pulse = flag set
    pt8_scale_if.scaler sc
);
    typedef struct packed {
        logic [3:0] cnt;
    } pt8_post_s;

    pt8_post_s st;
    pt8_post_s next_st;

    always_comb begin
        next_st = st;
        sc.pulse = sc.tick && !sc.clear && st.cnt == sc.sel;
        if (sc.clear) begin
            next_st.cnt = 4'h0;
        end else if (sc.tick) begin
            next_st.cnt = (st.cnt == sc.sel) ? 4'h0 : st.cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_post_clear: assert property (
        sc.clear |=> st.cnt == 4'h0)
        else $error("postscaler not cleared");
    a_post_oneone: assert property (
        sc.tick && !sc.clear && sc.sel == 4'h0 |-> sc.pulse)
        else $error("ratio 1:1 missed a match");
endmodule // pt8_postscaler

// >>> logic/pt8_prescaler.sv
`timescale 1ns/1ps
module pt8_prescaler
    import pt8_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // tick = run, sel[1:0] = prescale select, pulse = counter increment
    pt8_scale_if.scaler sc
);
    typedef struct packed {
        logic [1:0] qdiv;
        logic [3:0] cnt;
    } pt8_pre_s;

    pt8_pre_s st;
    pt8_pre_s next_st;
    logic [3:0] last;
    logic instr_en;

    always_comb begin
        next_st = st;
        unique case (sc.sel[PS_MSB:0])
            PRESC_SEL_1: last = PRESC_LAST_1;
            PRESC_SEL_4: last = PRESC_LAST_4;
            default: last = PRESC_LAST_16;
        endcase
        instr_en = st.qdiv == INSTR_LAST;
        next_st.qdiv = st.qdiv + 2'h1;
        sc.pulse = sc.tick && instr_en && !sc.clear && st.cnt == last;
        if (sc.clear) begin
            next_st.cnt = 4'h0;
        end else if (sc.tick && instr_en) begin
            next_st.cnt = (st.cnt == last) ? 4'h0 : st.cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_presc_ratio: assert property (
        sc.pulse && sc.sel[PS_MSB:0] == PRESC_SEL_4 |-> st.cnt == PRESC_LAST_4 && $past(st.qdiv) == 2'h2)
        else $error("prescale by four fired at wrong count");
    a_instr_rate: assert property (
        sc.pulse |=> !sc.pulse [*3])
        else $error("increments closer than the instruction clock");
endmodule // pt8_prescaler

// >>> logic/pt8_top.sv
`timescale 1ns/1ps
//
// Behaviour
// - 8-bit readable writable counter, reset to zero
// - increments from oscillator divided by four
// - prescale select: 1, 4, 16
// - counts from zero, wraps after period match
// - period register read/write, resets to FFh
// - postscaler counts matches, sets timer flag
// - postscale ratio is field plus one
// - run bit enables; cleared holds count
// - scalers clear on count/control write, reset
// - control write keeps the count unchanged
// - pre-postscaler match pulse to serial port
// - count and match offered to PWM units
// - control bit 7 reads zero, ignores writes
module pt8_top
    import pt8_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq,
    // serial port shift clock source
    output logic ssp_shift_tick,
    // pwm time base
    output logic [7:0] pwm_count,
    output logic pwm_period_match
);
    typedef struct packed {
        pt8_bus_e bus;
        logic rdy;
        logic err;
        logic [31:0] rdata;
        logic [7:0] count;
        logic [7:0] period;
        logic [6:0] ctrl;
        logic flag;
        logic [7:0] enable;
        logic irq;
        logic match;
    } pt8_top_s;

    pt8_top_s st;
    pt8_top_s next_st;

    pt8_scale_if pre_if ();
    pt8_scale_if post_if ();

    logic [9:0] idx;
    logic lane_ok;
    logic hit;
    logic fin;
    logic wr_count;
    logic wr_ctrl;
    logic wr_period;
    logic wr_enable;
    logic rd_flag;
    logic inc;
    logic match_evt;
    logic [31:0] rmux;

    assign idx = paddr[ADDR_W-1:2];
    assign lane_ok = paddr[1:0] == WORD_LANE;
    assign hit = lane_ok && (idx == IDX_FLAG || idx == IDX_COUNT || idx == IDX_CTRL
                             || idx == IDX_ENABLE || idx == IDX_PERIOD);
    // transfer completes on the edge where pready is seen high
    assign fin = psel && penable && st.rdy;
    assign wr_count = fin && pwrite && lane_ok && idx == IDX_COUNT;
    assign wr_ctrl = fin && pwrite && lane_ok && idx == IDX_CTRL;
    assign wr_period = fin && pwrite && lane_ok && idx == IDX_PERIOD;
    assign wr_enable = fin && pwrite && lane_ok && idx == IDX_ENABLE;
    assign rd_flag = fin && !pwrite && lane_ok && idx == IDX_FLAG;

    assign pre_if.clear = wr_count || wr_ctrl;
    assign pre_if.tick = st.ctrl[RUN_BIT];
    assign pre_if.sel = {2'h0, st.ctrl[PS_MSB:0]};
    assign inc = pre_if.pulse;

    assign match_evt = inc && st.count == st.period;
    assign post_if.clear = wr_count || wr_ctrl;
    assign post_if.tick = match_evt;
    assign post_if.sel = st.ctrl[POST_MSB:POST_LSB];

    pt8_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .sc(pre_if.scaler)
    );

    pt8_postscaler u_post (
        .pclk(pclk),
        .presetn(presetn),
        .sc(post_if.scaler)
    );

    always_comb begin
        rmux = 32'h0;
        unique case (1'b1)
            idx == IDX_FLAG: rmux[TMR_FLAG_BIT] = st.flag;
            idx == IDX_COUNT: rmux[7:0] = st.count;
            idx == IDX_CTRL: rmux[6:0] = st.ctrl;
            idx == IDX_ENABLE: rmux[7:0] = st.enable;
            idx == IDX_PERIOD: rmux[7:0] = st.period;
            default: rmux = 32'h0;
        endcase
        if (!lane_ok) begin
            rmux = 32'h0;
        end
    end

    always_comb begin
        next_st = st;
        next_st.match = match_evt;
        unique case (st.bus)
            PT8_IDLE: begin
                if (psel && penable) begin
                    next_st.bus = PT8_RESP;
                    next_st.rdy = 1'b1;
                    next_st.err = !hit;
                    next_st.rdata = pwrite ? 32'h0 : rmux;
                end
            end
            PT8_RESP: begin
                next_st.bus = PT8_IDLE;
                next_st.rdy = 1'b0;
                next_st.err = 1'b0;
            end
            default: begin
                next_st.bus = PT8_IDLE;
                next_st.rdy = 1'b0;
            end
        endcase

        if (wr_count) begin
            next_st.count = pwdata[7:0];
        end else if (inc) begin
            next_st.count = (st.count == st.period) ? COUNT_RST : st.count + 8'h1;
        end

        if (wr_ctrl) begin
            next_st.ctrl = pwdata[6:0];
        end
        if (wr_period) begin
            next_st.period = pwdata[7:0];
        end
        if (wr_enable) begin
            next_st.enable = pwdata[7:0];
        end

        // postscaler sets flag, set beats read clear
        if (post_if.pulse) begin
            next_st.flag = 1'b1;
        end else if (rd_flag) begin
            next_st.flag = 1'b0;
        end
        next_st.irq = next_st.flag && next_st.enable[TMR_EN_BIT];
    end

    // reset clears count, period to FFh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.bus <= PT8_IDLE;
            st.rdy <= 1'b0;
            st.err <= 1'b0;
            st.rdata <= 32'h0;
            st.count <= COUNT_RST;
            st.period <= PERIOD_RST;
            st.ctrl <= CTRL_RST;
            st.flag <= 1'b0;
            st.enable <= ENABLE_RST;
            st.irq <= 1'b0;
            st.match <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.rdata;
    assign pready = st.rdy;
    assign pslverr = st.err;
    assign irq = st.irq;
    assign ssp_shift_tick = st.match;
    assign pwm_count = st.count;
    assign pwm_period_match = st.match;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_count_step: assert property (
        inc && !wr_count && st.count != st.period |=> st.count == $past(st.count) + 8'h1)
        else $error("count did not step by one");

    a_count_read: assert property (
        fin && !pwrite && lane_ok && idx == IDX_COUNT |-> prdata == {24'h0, $past(st.count)})
        else $error("count read back wrong");

    a_match_wrap: assert property (
        inc && !wr_count && st.count == st.period |=> st.count == 8'h00 && ssp_shift_tick)
        else $error("count did not wrap after match");

    a_match_only: assert property (
        pwm_period_match |-> $past(st.count) == $past(st.period))
        else $error("match pulse without period match");

    a_presc_sixteen: assert property (
        st.ctrl[RUN_BIT] && st.ctrl[PS_MSB] && inc && !wr_count && !wr_ctrl
        ##1 (!wr_count && !wr_ctrl) [*8] |-> !inc [*1])
        else $error("prescale 16 incremented early");

    a_presc_four: assert property (
        (st.ctrl[PS_MSB:0] == PRESC_SEL_4 && inc && !wr_count && !wr_ctrl)
        ##1 (!wr_count && !wr_ctrl) [*8] |-> !inc)
        else $error("prescale 4 incremented early");

    a_presc_one: assert property (
        (st.ctrl[RUN_BIT] && st.ctrl[PS_MSB:0] == PRESC_SEL_1 && inc && !wr_count && !wr_ctrl)
        ##1 (!wr_count && !wr_ctrl) [*4] |-> inc)
        else $error("prescale 1 missed an increment");

    a_period_reset: assert property (
        $past(presetn) == 1'b0 |-> st.period == PERIOD_RST && st.count == COUNT_RST)
        else $error("period or count wrong after reset");

    a_period_load: assert property (
        wr_period |=> st.period == $past(pwdata[7:0]))
        else $error("period write not loaded");

    a_period_keep: assert property (
        !wr_period |=> $stable(st.period))
        else $error("period changed without a write");

    a_period_read: assert property (
        fin && !pwrite && lane_ok && idx == IDX_PERIOD |-> prdata == {24'h0, $past(st.period)})
        else $error("period read back wrong");

    a_run_hold: assert property (
        !st.ctrl[RUN_BIT] && !wr_count |=> $stable(st.count))
        else $error("count moved while stopped");

    a_run_inc: assert property (
        inc |-> st.ctrl[RUN_BIT])
        else $error("increment while stopped");

    a_run_stop: assert property (
        !st.ctrl[RUN_BIT] |-> !match_evt && !post_if.pulse)
        else $error("match while stopped");

    a_ctrl_keep: assert property (
        wr_ctrl && !wr_count |=> st.count == $past(st.count) && !ssp_shift_tick)
        else $error("control write disturbed the count");

    a_count_load: assert property (
        wr_count |=> st.count == $past(pwdata[7:0]))
        else $error("count write not loaded");

    a_load_count: assert property (
        wr_count |=> !ssp_shift_tick)
        else $error("match pulse after a count write");

    a_ctrl_bit7: assert property (
        fin && !pwrite && idx == IDX_CTRL ##0 $past(st.rdy) == 1'b0 |-> prdata[31:7] == 25'h0)
        else $error("control upper bits not zero");

    a_ctrl_store: assert property (
        wr_ctrl |=> st.ctrl == $past(pwdata[6:0]))
        else $error("control write not stored");

    a_ctrl_read: assert property (
        fin && !pwrite && lane_ok && idx == IDX_CTRL |-> prdata[6:0] == $past(st.ctrl))
        else $error("control read back wrong");

    a_flag_set: assert property (
        post_if.pulse |=> st.flag [*1] ##0 (irq == st.enable[TMR_EN_BIT]))
        else $error("postscaler pulse did not set flag");

    a_flag_hold: assert property (
        st.flag && !rd_flag |=> st.flag)
        else $error("flag dropped without a read");

    a_flag_clear: assert property (
        rd_flag && !post_if.pulse |=> !st.flag)
        else $error("flag read did not clear it");

    a_flag_cause: assert property (
        $rose(st.flag) |-> $past(post_if.pulse))
        else $error("flag set without postscaler pulse");

    a_flag_read: assert property (
        fin && !pwrite && lane_ok && idx == IDX_FLAG |-> prdata[TMR_FLAG_BIT] == $past(st.flag))
        else $error("flag read back wrong");

    a_post_one: assert property (
        match_evt && st.ctrl[POST_MSB:POST_LSB] == 4'h0 |=> st.flag)
        else $error("ratio 1:1 did not set flag");

    a_irq_level: assert property (
        irq |-> st.flag && st.enable[TMR_EN_BIT])
        else $error("interrupt without enabled flag");

    a_irq_set: assert property (
        st.flag && st.enable[TMR_EN_BIT] |-> irq)
        else $error("enabled flag without interrupt");

    a_irq_mask: assert property (
        !st.enable[TMR_EN_BIT] |-> !irq)
        else $error("masked interrupt raised");

    a_enable_load: assert property (
        wr_enable |=> st.enable == $past(pwdata[7:0]))
        else $error("enable write not loaded");

    a_enable_keep: assert property (
        !wr_enable |=> $stable(st.enable))
        else $error("enable changed without a write");

    a_ssp_tick: assert property (
        match_evt |=> ssp_shift_tick && pwm_period_match)
        else $error("match pulse not delivered");

    a_tick_width: assert property (
        ssp_shift_tick |=> !ssp_shift_tick)
        else $error("match pulse longer than one cycle");

    a_scaler_clear: assert property (
        wr_count || wr_ctrl |-> !inc && !post_if.pulse)
        else $error("scaler fired during a clearing write");

    a_pwm_base: assert property (
        pwm_period_match |-> pwm_count == 8'h00 || $past(wr_count))
        else $error("pwm match without wrapped count");
endmodule // pt8_top

// >>> verification/pt8_tb.sv
`timescale 1ns/1ps
module tb;
    import pt8_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic ssp_shift_tick;
    logic pwm_period_match;
    logic [7:0] pwm_count;
    int bad_count = 0;
    int tests_run = 0;
    int seed = 32'h6160;
    // model state
    logic [7:0] m_period = 8'hff;
    logic [7:0] m_count = 8'h00;
    logic [7:0] prev = 8'h00;
    int gap_exp = 4;
    int cyc = 0;
    int last_step = 0;
    int steps = 0;
    int ticks = 0;
    logic watch = 1'b0;
    logic seen = 1'b0;
    logic [31:0] rd;
    logic er;

    always #25 pclk = ~pclk;

    pt8_top pt8_top_inst (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .irq(irq),
        .ssp_shift_tick(ssp_shift_tick),
        .pwm_count(pwm_count),
        .pwm_period_match(pwm_period_match)
    );

    task automatic close_out;
        $display("mismatches %0d, checks %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] idx, input logic [1:0] lane, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, lane};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: no bus answer", $time);
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, WORD_LANE, d);
    endtask

    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, WORD_LANE, 32'h0);
        chk({er, rd}, {1'b0, exp});
    endtask

    task automatic wait_irq(input logic lvl);
        int n;
        for (n = 0; n < 400 && irq !== lvl; n++) begin
            @(posedge pclk);
        end
        if (irq !== lvl) begin
            bad_count++;
            $display("Error at %0t: interrupt wait ran out", $time);
            close_out();
        end
    endtask

    // step monitor: every count change is an increment or a wrap
    always @(posedge pclk) begin
        if (pwm_period_match === 1'b1) begin
            ticks++;
        end
        if (watch) begin
            cyc++;
            if (pwm_count !== prev) begin
                steps++;
                chk(pwm_count, (prev == m_period) ? 8'h00 : 8'(prev + 8'h01));
                if (seen) begin
                    chk(cyc - last_step, gap_exp);
                end
                seen = 1'b1;
                last_step = cyc;
            end
            chk({ssp_shift_tick, pwm_period_match}, {2{pwm_count !== prev && prev == m_period}});
        end else begin
            seen = 1'b0;
        end
        prev = pwm_count;
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(IDX_COUNT, 32'h0);
        rdc(IDX_CTRL, 32'h0);
        rdc(IDX_ENABLE, 32'h0);
        rdc(IDX_PERIOD, 32'hff);
        rdc(IDX_FLAG, 32'h0);
        // unmapped and misaligned places are refused
        apb(1'b0, 10'h001, WORD_LANE, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b1, IDX_COUNT, 2'h1, 32'h55);
        chk(er, 1'b1);
        rdc(IDX_COUNT, 32'h0);
        wr(IDX_CTRL, 32'hfb);
        rdc(IDX_CTRL, 32'h7b);
        wr(IDX_ENABLE, 32'ha5);
        rdc(IDX_ENABLE, 32'ha5);
        m_period = 8'($random(seed)) | 8'h04;
        wr(IDX_PERIOD, {24'h0, m_period});
        rdc(IDX_PERIOD, {24'h0, m_period});
        for (int c = 0; c < 4; c++) begin
            gap_exp = INSTR_DIV * ((c == 0) ? 1 : (c == 1) ? 4 : 16);
            wr(IDX_CTRL, 32'h0);
            wr(IDX_COUNT, 32'h0);
            wr(IDX_CTRL, 32'h4 | c);
            steps = 0;
            watch = 1'b1;
            repeat (gap_exp * 4) @(posedge pclk);
            watch = 1'b0;
            chk(steps >= 3, 1'b1);
        end
        m_period = 8'h01;
        wr(IDX_PERIOD, 32'h1);
        wr(IDX_ENABLE, 32'h2);
        gap_exp = INSTR_DIV;
        for (int p = 0; p < 16; p++) begin
            wr(IDX_CTRL, 32'h0);
            wr(IDX_COUNT, 32'h0);
            apb(1'b0, IDX_FLAG, WORD_LANE, 32'h0);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0);
            ticks = 0;
            wr(IDX_CTRL, 32'h4 | (p << 3));
            watch = 1'b1;
            wait_irq(1'b1);
            repeat (2) @(posedge pclk);
            chk(ticks, p + 1);
            watch = 1'b0;
        end
        // mask, unmask, then clear by reading
        wr(IDX_CTRL, 32'h0);
        wr(IDX_ENABLE, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        wr(IDX_ENABLE, 32'h2);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        rdc(IDX_FLAG, 32'h2);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        rdc(IDX_FLAG, 32'h0);
        m_count = 8'($random(seed)) & 8'h7f;
        wr(IDX_COUNT, {24'h0, m_count});
        repeat (40) @(posedge pclk);
        rdc(IDX_COUNT, {24'h0, m_count});
        wr(IDX_CTRL, 32'h78);
        rdc(IDX_COUNT, {24'h0, m_count});
        m_period = 8'hff;
        wr(IDX_PERIOD, 32'hff);
        gap_exp = INSTR_DIV;
        wr(IDX_CTRL, 32'h4);
        steps = 0;
        watch = 1'b1;
        repeat (12) @(posedge pclk);
        watch = 1'b0;
        chk(steps >= 1, 1'b1);
        // second reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(IDX_COUNT, 32'h0);
        rdc(IDX_PERIOD, 32'hff);
        rdc(IDX_CTRL, 32'h0);
        close_out();
    end
endmodule // tb
